// >>> src/rpcs_port_regs.v
`timescale 1ns/1ps
`include "rpcs_consts.vh"
// What this block does
// - Setting the start bit makes the link actively start a connection.
// - Setting the disable bit stops the link starting or answering the far end.
// - With deactivate set, data and strobe outputs are off in ErrorReset, ErrorWait, Ready.
// - On deactivation the data output goes off one clock before the strobe output.
// - The seven-bit transmit rate field sets the transmitter signalling rate.
// - On the first clock after reset the low three rate bits load from straps and the rest clear.
// - The external summary error bit is set whenever any external error bit is set.
// - The external address error sets on a bad address or an empty packet.
// - The external timeout error sets when the output stays blocked too long.
// - Bits 3 and 4 show external input buffer empty and full.
// - Bits 5 and 6 show external output buffer empty and full.
// - Error bits hold until the error-active clear, not a port register write.
// - Auto-start resets to one and starts the link when the far end tries.
// - Bits 10:8 report the link interface state.
module rpcs_port_regs #(
    parameter RATE_W = 7
) (
    // Clock and reset
    input  wire        mclk_i,
    input  wire        rst_i,
    // Rate straps
    input  wire [2:0]  rate_strap_i,
    // Link port register access
    input  wire        link_wr_i,
    input  wire [31:0] link_wdata_i,
    output reg  [31:0] link_rdata_o,
    // External port register read
    output reg  [31:0] ext_rdata_o,
    // Error clear from error-active register write
    input  wire        err_clear_i,
    // Link interface
    input  wire [2:0]  link_state_i,
    output reg         link_start_o,
    output reg         link_auto_o,
    output reg         link_disable_o,
    output reg  [RATE_W-1:0] transmit_rate_setting_o,
    output reg         dout_en_o,
    output reg         sout_en_o,
    // External port events
    input  wire        ext_addr_err_i,
    input  wire        ext_empty_pkt_i,
    input  wire        ext_tmo_err_i,
    input  wire        ext_in_empty_i,
    input  wire        ext_in_full_i,
    input  wire        ext_out_empty_i,
    input  wire        ext_out_full_i
);
    // ----------------------------------------
    // Internal state
    // ----------------------------------------
    reg              auto_reg;
    reg              auto_next;
    reg              start_reg;
    reg              start_next;
    reg              dis_reg;
    reg              dis_next;
    reg              deact_reg;
    reg              deact_next;
    reg [RATE_W-1:0] rate_reg;
    reg [RATE_W-1:0] rate_next;
    reg              strap_pend_reg;
    reg              addr_err_reg;
    reg              addr_err_next;
    reg              tmo_err_reg;
    reg              tmo_err_next;
    reg              dout_en_next;
    reg              sout_en_next;
    reg [31:0]       link_rdata_next;
    reg [31:0]       ext_rdata_next;
    wire             ena_state;
    wire             addr_evt;
    wire             err_act;

    // ----------------------------------------
    // Control field writes
    // ----------------------------------------
    always @* begin
        auto_next  = auto_reg;
        start_next = start_reg;
        dis_next   = dis_reg;
        deact_next = deact_reg;
        if (link_wr_i) begin
            auto_next  = link_wdata_i[`RPCS_LS_AUTOSTART];
            start_next = link_wdata_i[`RPCS_LS_START];
            dis_next   = link_wdata_i[`RPCS_LS_DISABLE];
            deact_next = link_wdata_i[`RPCS_LS_DEACT];
        end
    end

    // ----------------------------------------
    // Transmit rate field
    // ----------------------------------------
    // Straps win over a write on the capture edge
    always @* begin
        rate_next = rate_reg;
        if (strap_pend_reg) begin
            rate_next = {{(RATE_W-3){1'b0}}, rate_strap_i};
        end else if (link_wr_i) begin
            rate_next = link_wdata_i[`RPCS_LS_RATE_LSB +: RATE_W];
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    // Reset loads constants only; straps are taken once reset is gone
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            auto_reg       <= `RPCS_LS_AUTO_RST;
            start_reg      <= `RPCS_LS_CTRL_RST;
            dis_reg        <= `RPCS_LS_CTRL_RST;
            deact_reg      <= `RPCS_LS_CTRL_RST;
            rate_reg       <= {RATE_W{1'b0}};
            strap_pend_reg <= 1'b1;
        end else begin
            auto_reg       <= auto_next;
            start_reg      <= start_next;
            dis_reg        <= dis_next;
            deact_reg      <= deact_next;
            rate_reg       <= rate_next;
            strap_pend_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Output enable mapping
    // ----------------------------------------
    assign ena_state = (link_state_i == `RPCS_ST_STARTED) ||
                       (link_state_i == `RPCS_ST_CONNECTING) ||
                       (link_state_i == `RPCS_ST_RUN);

    // Strobe holds one clock longer on turn-off; on turn-on data and strobe switch together
    always @* begin
        dout_en_next = ~deact_reg | ena_state;
        sout_en_next = dout_en_next | dout_en_o;
    end

    // ----------------------------------------
    // External error flags
    // ----------------------------------------
    assign addr_evt = ext_addr_err_i | ext_empty_pkt_i;

    // Set wins over a clear in the same clock, so no event is lost
    always @* begin
        addr_err_next = addr_err_reg;
        tmo_err_next  = tmo_err_reg;
        if (addr_evt) begin
            addr_err_next = 1'b1;
        end else if (err_clear_i) begin
            addr_err_next = 1'b0;
        end
        if (ext_tmo_err_i) begin
            tmo_err_next = 1'b1;
        end else if (err_clear_i) begin
            tmo_err_next = 1'b0;
        end
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_err_reg <= 1'b0;
            tmo_err_reg  <= 1'b0;
        end else begin
            addr_err_reg <= addr_err_next;
            tmo_err_reg  <= tmo_err_next;
        end
    end

    assign err_act = addr_err_reg | tmo_err_reg;

    // ----------------------------------------
    // Link port read image
    // ----------------------------------------
    // Low error bits of this register live elsewhere and read zero here
    always @* begin
        link_rdata_next = 32'h0;
        link_rdata_next[`RPCS_LS_STATE_LSB+2:`RPCS_LS_STATE_LSB] = link_state_i;
        link_rdata_next[`RPCS_LS_RUNNING]   = (link_state_i == `RPCS_ST_RUN);
        link_rdata_next[`RPCS_LS_AUTOSTART] = auto_reg;
        link_rdata_next[`RPCS_LS_START]     = start_reg;
        link_rdata_next[`RPCS_LS_DISABLE]   = dis_reg;
        link_rdata_next[`RPCS_LS_DEACT]     = deact_reg;
        link_rdata_next[`RPCS_LS_RATE_LSB +: RATE_W] = rate_reg;
    end

    // ----------------------------------------
    // External port read image
    // ----------------------------------------
    always @* begin
        ext_rdata_next = 32'h0;
        ext_rdata_next[`RPCS_EX_ERR_ACT]   = err_act;
        ext_rdata_next[`RPCS_EX_ADDR_ERR]  = addr_err_reg;
        ext_rdata_next[`RPCS_EX_TMO_ERR]   = tmo_err_reg;
        ext_rdata_next[`RPCS_EX_IN_EMPTY]  = ext_in_empty_i;
        ext_rdata_next[`RPCS_EX_IN_FULL]   = ext_in_full_i;
        ext_rdata_next[`RPCS_EX_OUT_EMPTY] = ext_out_empty_i;
        ext_rdata_next[`RPCS_EX_OUT_FULL]  = ext_out_full_i;
    end

    // ----------------------------------------
    // Output registers
    // ----------------------------------------
    // Every output leaves from a flop; reads lag the fields by one clock
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            link_start_o            <= 1'b0;
            link_auto_o             <= 1'b0;
            link_disable_o          <= 1'b0;
            transmit_rate_setting_o <= {RATE_W{1'b0}};
            dout_en_o               <= 1'b0;
            sout_en_o               <= 1'b0;
            link_rdata_o            <= 32'h0;
            ext_rdata_o             <= 32'h0;
        end else begin
            link_start_o            <= start_reg & ~dis_reg;
            link_auto_o             <= auto_reg & ~dis_reg;
            link_disable_o          <= dis_reg;
            transmit_rate_setting_o <= rate_reg;
            dout_en_o               <= dout_en_next;
            sout_en_o               <= sout_en_next;
            link_rdata_o            <= link_rdata_next;
            ext_rdata_o             <= ext_rdata_next;
        end
    end
endmodule // rpcs_port_regs

// >>> src/rpcs_consts.vh
`ifndef RPCS_CONSTS_VH
`define RPCS_CONSTS_VH
// ----------------------------------------
// Link port register fields
// ----------------------------------------
`define RPCS_LS_STATE_LSB   8
`define RPCS_LS_RUNNING     11
`define RPCS_LS_AUTOSTART   12
`define RPCS_LS_START       13
`define RPCS_LS_DISABLE     14
`define RPCS_LS_DEACT       15
`define RPCS_LS_RATE_LSB    16
`define RPCS_LS_RATE_MSB    22
`define RPCS_LS_AUTO_RST    1'b1
`define RPCS_LS_CTRL_RST    1'b0
`define RPCS_LS_RATE_HI_RST 4'h0
// ----------------------------------------
// Link interface state codes
// ----------------------------------------
`define RPCS_ST_ERR_RESET   3'h0
`define RPCS_ST_ERR_WAIT    3'h1
`define RPCS_ST_READY       3'h2
`define RPCS_ST_STARTED     3'h3
`define RPCS_ST_CONNECTING  3'h4
`define RPCS_ST_RUN         3'h5
// ----------------------------------------
// External port status fields
// ----------------------------------------
`define RPCS_EX_ERR_ACT     0
`define RPCS_EX_ADDR_ERR    1
`define RPCS_EX_TMO_ERR     2
`define RPCS_EX_IN_EMPTY    3
`define RPCS_EX_IN_FULL     4
`define RPCS_EX_OUT_EMPTY   5
`define RPCS_EX_OUT_FULL    6
`endif

// >>> testbench/rpcs_port_regs_checker.sv
`timescale 1ns/1ps
// ----
// Checker
// ----
module rpcs_port_regs_checker (
    input wire        mclk_i, rst_i, link_wr_i, err_clear_i,
    input wire [31:0] link_wdata_i, link_rdata_o, ext_rdata_o,
    input wire        link_start_o, link_disable_o, dout_en_o, sout_en_o,
    input wire        ext_addr_err_i, ext_empty_pkt_i, ext_tmo_err_i,
    input wire        ext_in_empty_i, ext_in_full_i, ext_out_empty_i, ext_out_full_i
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_wr; link_wr_i ##1 !link_wr_i; endsequence
    sequence s_go; link_wr_i && link_wdata_i[14:13] == 2'b01 ##1 !link_wr_i; endsequence
    property p_start; s_go |-> ##1 link_start_o; endproperty
    a_start: assert property (p_start) else $error("start lost");
    property p_dis; link_disable_o |-> !link_start_o; endproperty
    a_dis: assert property (p_dis) else $error("start when disabled");
    property p_rate; s_wr |-> ##1 link_rdata_o[22:16] == $past(link_wdata_i[22:16], 2); endproperty
    a_rate: assert property (p_rate) else $error("rate field");
    property p_sum; ext_rdata_o[0] == (ext_rdata_o[1] | ext_rdata_o[2]); endproperty
    a_sum: assert property (p_sum) else $error("summary bit");
    property p_addr; ext_addr_err_i || ext_empty_pkt_i |-> ##2 ext_rdata_o[1]; endproperty
    a_addr: assert property (p_addr) else $error("address error");
    property p_tmo; ext_tmo_err_i |-> ##2 ext_rdata_o[2]; endproperty
    a_tmo: assert property (p_tmo) else $error("timeout error");
    property p_hold; !err_clear_i && !$past(err_clear_i) |=>
        (ext_rdata_o[2:1] & $past(ext_rdata_o[2:1])) == $past(ext_rdata_o[2:1]); endproperty
    a_hold: assert property (p_hold) else $error("error bit dropped");
    property p_buf; !$past(rst_i) |-> ext_rdata_o[6:3] ==
        $past({ext_out_full_i, ext_out_empty_i, ext_in_full_i, ext_in_empty_i}); endproperty
    a_buf: assert property (p_buf) else $error("buffer flags");
    // Data must go quiet a clock ahead of strobe
    property p_deact; $fell(dout_en_o) |-> sout_en_o ##1 (dout_en_o || !sout_en_o); endproperty
    a_deact: assert property (p_deact) else $error("enable order");
endmodule // rpcs_port_regs_checker
bind rpcs_port_regs rpcs_port_regs_checker u_rpcs_port_regs_checker (
    .mclk_i(mclk_i), .rst_i(rst_i), .link_wr_i(link_wr_i), .err_clear_i(err_clear_i),
    .link_wdata_i(link_wdata_i), .link_rdata_o(link_rdata_o), .ext_rdata_o(ext_rdata_o),
    .link_start_o(link_start_o), .link_disable_o(link_disable_o), .dout_en_o(dout_en_o),
    .sout_en_o(sout_en_o), .ext_addr_err_i(ext_addr_err_i), .ext_empty_pkt_i(ext_empty_pkt_i),
    .ext_tmo_err_i(ext_tmo_err_i), .ext_in_empty_i(ext_in_empty_i), .ext_in_full_i(ext_in_full_i),
    .ext_out_empty_i(ext_out_empty_i), .ext_out_full_i(ext_out_full_i));

// >>> testbench/tb_router_port_control_status.sv
`timescale 1ns/1ps
module tb_router_port_control_status;
    reg         mclk_i = 1'b0, rst_i = 1'b1, link_wr_i = 1'b0, err_clear_i = 1'b0, look = 1'b0;
    reg  [2:0]  strap = 3'h0, state = 3'h5, ev = 3'h0;
    reg  [3:0]  bf = 4'h0;
    reg  [6:0]  r;
    reg  [1:0]  s_c, q_s[$];
    reg  [31:0] wd = 32'h0, lf = 32'h29a8, m_c, v_c, q_m[$], q_v[$];
    wire [31:0] lrd, erd;
    wire [6:0]  rate;
    wire        st, au, ds, de, se;
    integer     err_count = 0, tests_run = 0, cyc = 0, i;
    always #2.5 mclk_i = ~mclk_i;
    rpcs_port_regs u_rpcs_port_regs (.mclk_i(mclk_i), .rst_i(rst_i), .rate_strap_i(strap),
        .link_wr_i(link_wr_i), .link_wdata_i(wd), .link_rdata_o(lrd), .ext_rdata_o(erd),
        .err_clear_i(err_clear_i), .link_state_i(state), .link_start_o(st), .link_auto_o(au),
        .link_disable_o(ds), .transmit_rate_setting_o(rate), .dout_en_o(de), .sout_en_o(se),
        .ext_addr_err_i(ev[0]), .ext_empty_pkt_i(ev[1]), .ext_tmo_err_i(ev[2]),
        .ext_in_empty_i(bf[0]), .ext_in_full_i(bf[1]), .ext_out_empty_i(bf[2]),
        .ext_out_full_i(bf[3]));
    function [31:0] nx(input [31:0] x); nx = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]}; endfunction
    task tick(input integer n); repeat (n) @(posedge mclk_i); endtask
    task note(input [1:0] s, input [31:0] m, input [31:0] v); begin
        tick(3); q_s.push_back(s); q_m.push_back(m); q_v.push_back(v & m);
        look <= 1'b1; tick(1); look <= 1'b0; end
    endtask
    task wr(input [31:0] d); begin
        @(posedge mclk_i); link_wr_i <= 1'b1; wd <= d;
        @(posedge mclk_i); link_wr_i <= 1'b0; wd <= ~d; end
    endtask
    task pulse(input [2:0] e, input c); begin
        @(posedge mclk_i); ev <= e; err_clear_i <= c;
        @(posedge mclk_i); ev <= 3'h0; err_clear_i <= 1'b0; end
    endtask
    task cmp_reg(input [1:0] s, input [31:0] e, input [31:0] g); begin
        tests_run = tests_run + 1;
        if (g !== e) begin err_count = err_count + 1;
        $display("unexpected %s exp %h got %h", s[0] ? "ext_rdata_o" : "link_rdata_o", e, g); end end
    endtask
    task cmp_out(input [31:0] e, input [31:0] g); begin
        tests_run = tests_run + 1;
        if (g !== e) begin err_count = err_count + 1;
        $display("unexpected control_outputs exp %h got %h", e, g); end end
    endtask
    task print_verdict; begin
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish; end
    endtask
    // ----
    // Watcher and hang guard
    // ----
    always @(posedge mclk_i) begin
        cyc = cyc + 1;
        if (cyc > 2000) begin err_count = err_count + 1; print_verdict; end
        else if (look) begin
            s_c = q_s.pop_front(); m_c = q_m.pop_front(); v_c = q_v.pop_front();
            if (s_c == 2'd2) cmp_out(v_c, m_c & {20'h0, de, se, ds, au, st, rate});
            else cmp_reg(s_c, v_c, m_c & (s_c[0] ? erd : lrd));
        end
    end
    // ----
    // Scenarios
    // ----
    initial begin
        lf = nx(lf); strap <= lf[2:0];
        tick(3); rst_i <= 1'b0;
        note(0, 32'hfffff000, {13'h0, strap, 16'h1000});
        note(2, 32'hfff, {20'h0, 5'h1a, 4'h0, strap});
        lf = nx(lf); r = {1'b0, lf[21:17], 1'b1};
        wr({lf[31:23], r, 4'h3, lf[11:0]});
        note(0, 32'hfffff000, {9'h0, r, 4'h3, 12'h0});
        note(2, 32'hfff, {20'h0, 5'h1b, r});
        wr({9'h0, r, 4'h7, 12'h0});
        note(2, 32'hfff, {20'h0, 5'h1c, r});
        wr({9'h0, r, 4'h9, 12'h0});
        for (i = 0; i < 6; i = i + 1) begin
            state <= i[2:0];
            note(2, 32'hc00, {20'h0, {2{i > 2}}, 10'h0});
            note(0, 32'h700, i << 8);
        end
        pulse(3'h1, 1'b0); note(1, 32'h7, 32'h3);
        wr({9'h0, r, 4'h1, 12'h0}); note(1, 32'h7, 32'h3);
        pulse(3'h0, 1'b1); note(1, 32'h7, 32'h0);
        pulse(3'h2, 1'b0); note(1, 32'h7, 32'h3);
        pulse(3'h4, 1'b1); note(1, 32'h7, 32'h5);
        pulse(3'h0, 1'b1); note(1, 32'h7, 32'h0);
        for (i = 0; i < 4; i = i + 1) begin
            lf = nx(lf); bf <= lf[3:0];
            note(1, 32'hffffffff, {25'h0, lf[3:0], 3'h0});
        end
        tick(3); print_verdict;
    end
endmodule // tb_router_port_control_status
